// ==== core/osq_pkg.sv ====
// Shared constants and types for the status reporting and output queue block
package osq_pkg;

	localparam int          OSQ_W        = 16;
	localparam int          OSQ_GROUPS   = 3;
	localparam int          OSQ_DEPTH    = 4;
	localparam int          OSQ_AW       = 2;
	localparam int          OSQ_CW       = 3;
	localparam int          OSQ_PINS     = 7;
	localparam logic [15:0] WORD_MASK    = 16'h7FFF;
	localparam logic [15:0] WORD_ZERO    = 16'h0000;
	localparam logic [15:0] RISE_RST     = 16'h7FFF;
	localparam logic [15:0] FALL_RST     = 16'h0000;
	localparam logic [15:0] EVT_RST      = 16'h0000;
	localparam logic [15:0] MASK_RST     = 16'h0000;
	localparam logic [2:0]  CNT_EMPTY    = 3'h0;
	localparam logic [2:0]  CNT_FULL     = 3'h4;

	// Operation group condition bit positions
	localparam int          OPER_PROG    = 14;
	localparam int          OPER_CDMA2   = 10;
	localparam int          OPER_CALLP   = 9;
	localparam int          OPER_CDMA    = 8;
	localparam int          OPER_MEAS    = 4;
	localparam int          OPER_CAL     = 0;
	// Questionable group condition bit positions
	localparam int          QUES_WARN    = 14;
	localparam int          QUES_CAL     = 8;
	// Measuring group condition bit position
	localparam int          MEAS_FER     = 0;

	// Pin vector positions
	localparam int          PIN_PROG     = 0;
	localparam int          PIN_FER      = 1;
	localparam int          PIN_CDMA2    = 2;
	localparam int          PIN_CALLP    = 3;
	localparam int          PIN_CDMA     = 4;
	localparam int          PIN_CAL      = 5;
	localparam int          PIN_WARN     = 6;

	typedef enum logic [1:0] {
		GRP_MEAS = 2'b00,
		GRP_OPER = 2'b01,
		GRP_QUES = 2'b10
	} osq_grp_t;

	typedef enum logic [2:0] {
		REG_COND = 3'b000,
		REG_RISE = 3'b001,
		REG_FALL = 3'b010,
		REG_EVT  = 3'b011,
		REG_MASK = 3'b100
	} osq_reg_t;

	typedef enum logic [1:0] {
		OP_READ  = 2'b00,
		OP_WRITE = 2'b01,
		OP_CLEAR = 2'b10
	} osq_op_t;

	typedef struct packed {
		logic        valid;
		osq_op_t     op;
		osq_grp_t    grp;
		osq_reg_t    sel;
		logic [15:0] data;
	} osq_cmd_t;

	typedef struct packed {
		logic        wr;
		logic        rd_evt;
		logic        cls;
		osq_reg_t    sel;
		logic [15:0] data;
	} osq_acc_t;

	typedef struct packed {
		logic [15:0] cond;
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] evt;
		logic [15:0] mask;
	} osq_regs_t;

endpackage : osq_pkg

// ==== core/osq_group.sv ====
// One status register group: condition, edge filters, event latch, event mask
`timescale 1ns/1ps
`default_nettype none
module osq_group
	import osq_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [15:0] cond,
	input  wire osq_pkg::osq_acc_t acc,
	output osq_pkg::osq_regs_t regs,
	output logic            summary
);
	typedef struct packed {
		logic [15:0] prev;
		logic [15:0] rise;
		logic [15:0] fall;
		logic [15:0] evt;
		logic [15:0] mask;
	} osq_grp_state_t;

	osq_grp_state_t s_q;
	osq_grp_state_t s_d;
	logic [15:0]    edges;
	logic [15:0]    cond_m;

	always_comb begin
		s_d    = s_q;
		cond_m = cond & WORD_MASK;
		edges  = (cond_m & ~s_q.prev & s_q.rise) | (~cond_m & s_q.prev & s_q.fall);
		s_d.prev = cond_m;
		// Clear on query or clear-status; new edges still win
		s_d.evt = (((acc.rd_evt | acc.cls) ? WORD_ZERO : s_q.evt) | edges) & WORD_MASK;
		if (acc.wr) begin
			unique case (acc.sel)
				REG_RISE: s_d.rise = acc.data & WORD_MASK;
				REG_FALL: s_d.fall = acc.data & WORD_MASK;
				REG_MASK: s_d.mask = acc.data & WORD_MASK;
				default:  s_d.rise = s_q.rise;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '{prev: WORD_ZERO, rise: RISE_RST, fall: FALL_RST,
			         evt: EVT_RST, mask: MASK_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign regs = '{cond: cond_m, rise: s_q.rise, fall: s_q.fall, evt: s_q.evt, mask: s_q.mask};
	assign summary = |(s_q.evt & s_q.mask);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	chk_evt_read_clear: assert property (
		(acc.rd_evt && edges == WORD_ZERO) |=> regs.evt == WORD_ZERO)
		else $error("event latch not cleared after query");
	chk_bit15_low: assert property (
		!regs.cond[15] && !regs.rise[15] && !regs.fall[15] && !regs.evt[15] && !regs.mask[15])
		else $error("bit 15 not zero");
	chk_rise_latch: assert property (
		(|(cond_m & ~$past(cond_m) & regs.rise)) |=>
		|(regs.evt & $past(cond_m) & ~$past(cond_m, 2) & $past(regs.rise)))
		else $error("rising edge not latched");
	chk_mask_zero: assert property (
		(acc.wr && acc.sel == REG_MASK && acc.data == WORD_ZERO) |=> regs.mask == WORD_ZERO)
		else $error("mask not cleared by zero write");
	chk_filter_write: assert property (
		(acc.wr && acc.sel == REG_FALL) |=> regs.fall == ($past(acc.data) & WORD_MASK))
		else $error("fall filter write lost");
	chk_summary_hold: assert property (
		(summary && !acc.rd_evt && !acc.cls && !acc.wr) |=> summary)
		else $error("summary dropped without clear");
endmodule : osq_group
`default_nettype wire

// ==== core/osq_status_top.sv ====
// Status groups, status byte summary bits and output queue of the remote interface
// What this block does
// - Event register query or clear-status empties a group's event latch
// - Operation summary drives status byte bit seven
// - Bit 15 of every register stays zero
// - Operation bit 14 follows user program activity
// - Operation bits 10,9,8 take subordinate summaries
// - Summary high while enabled event is latched
// - Measuring summary feeds operation bit 4
// - Both edge filters readable and writable
// - Measuring group has only bit 0
// - Writing zero clears the event mask
// - Query answers wait in the output queue
// - Output queue is FIFO with message-available
// - Message-available bit high while queue holds data
// - No new command until output is read
// - Questionable summary drives status byte bit three
// - Calibration summary enters questionable condition
// - Questionable bit 14 flags ignored parameter
`timescale 1ns/1ps
`default_nettype none
module osq_status_top
	import osq_pkg::*;
(
	input  wire logic                 SYS_CLK,
	input  wire logic                 RST_N,
	input  wire osq_pkg::osq_cmd_t    CMD,
	output logic                      CMD_READY,
	input  wire logic                 OQ_READ,
	output logic [15:0]               OQ_DATA,
	output logic                      OQ_DATA_VALID,
	input  wire logic                 USER_PROGRAM_ACTIVE,
	input  wire logic                 FRAME_ERROR_TEST_ACTIVE,
	input  wire logic                 CDMA2_SUMMARY,
	input  wire logic                 CALL_PROC_SUMMARY,
	input  wire logic                 CDMA_SUMMARY,
	input  wire logic                 CAL_SUMMARY,
	input  wire logic                 COMMAND_WARNING,
	output logic                      STB_OPER_SUMMARY,
	output logic                      STB_QUES_SUMMARY,
	output logic                      STB_MESSAGE_AVAILABLE
);
	import osq_pkg::*;

	typedef struct packed {
		logic [OSQ_PINS-1:0]                 sync1;
		logic [OSQ_PINS-1:0]                 sync2;
		logic [OSQ_DEPTH-1:0][15:0]          mem;
		logic [OSQ_AW-1:0]                   wr_ptr;
		logic [OSQ_AW-1:0]                   rd_ptr;
		logic [OSQ_CW-1:0]                   count;
		logic                                ready;
		logic                                message_available;
		logic                                stb_oper;
		logic                                stb_ques;
		logic [15:0]                         oq_data;
		logic                                oq_valid;
	} osq_top_state_t;

	osq_top_state_t           st_q;
	osq_top_state_t           st_d;
	logic [OSQ_PINS-1:0]      pins;
	logic                     accept;
	logic                     push;
	logic                     pop;
	logic [15:0]              rd_word;
	osq_acc_t  [OSQ_GROUPS-1:0] acc;
	osq_regs_t [OSQ_GROUPS-1:0] regs;
	logic [OSQ_GROUPS-1:0][15:0] cond;
	logic [OSQ_GROUPS-1:0]    sum;

	assign pins[PIN_PROG]  = USER_PROGRAM_ACTIVE;
	assign pins[PIN_FER]   = FRAME_ERROR_TEST_ACTIVE;
	assign pins[PIN_CDMA2] = CDMA2_SUMMARY;
	assign pins[PIN_CALLP] = CALL_PROC_SUMMARY;
	assign pins[PIN_CDMA]  = CDMA_SUMMARY;
	assign pins[PIN_CAL]   = CAL_SUMMARY;
	assign pins[PIN_WARN]  = COMMAND_WARNING;

	// Commands taken only with an empty queue
	assign accept = CMD.valid && st_q.ready;

	// Measuring group only carries bit 0
	always_comb begin
		cond[GRP_MEAS]           = WORD_ZERO;
		cond[GRP_MEAS][MEAS_FER] = st_q.sync2[PIN_FER];
	end

	always_comb begin
		cond[GRP_OPER]              = WORD_ZERO;
		cond[GRP_OPER][OPER_PROG]   = st_q.sync2[PIN_PROG];
		cond[GRP_OPER][OPER_CDMA2]  = st_q.sync2[PIN_CDMA2];
		cond[GRP_OPER][OPER_CALLP]  = st_q.sync2[PIN_CALLP];
		cond[GRP_OPER][OPER_CDMA]   = st_q.sync2[PIN_CDMA];
		cond[GRP_OPER][OPER_MEAS]   = sum[GRP_MEAS];
		cond[GRP_OPER][OPER_CAL]    = st_q.sync2[PIN_CAL];
	end

	always_comb begin
		cond[GRP_QUES]              = WORD_ZERO;
		cond[GRP_QUES][QUES_WARN]   = st_q.sync2[PIN_WARN];
		cond[GRP_QUES][QUES_CAL]    = st_q.sync2[PIN_CAL];
	end

	// Unused fourth slot of the group field decodes to nothing
	genvar g;
	generate
		for (g = 0; g < OSQ_GROUPS; g++) begin : g_grp
			assign acc[g].wr     = accept && CMD.op == OP_WRITE && CMD.grp == osq_grp_t'(g);
			assign acc[g].rd_evt = accept && CMD.op == OP_READ && CMD.grp == osq_grp_t'(g)
			                       && CMD.sel == REG_EVT;
			assign acc[g].cls    = accept && CMD.op == OP_CLEAR;
			assign acc[g].sel    = CMD.sel;
			assign acc[g].data   = CMD.data;

			osq_group u_grp (
				.clk     (SYS_CLK),
				.rst_n   (RST_N),
				.cond    (cond[g]),
				.acc     (acc[g]),
				.regs    (regs[g]),
				.summary (sum[g])
			);
		end
	endgenerate

	// Query answer mux
	always_comb begin
		rd_word = WORD_ZERO;
		if (CMD.grp != GRP_MEAS && CMD.grp != GRP_OPER && CMD.grp != GRP_QUES) begin
			rd_word = WORD_ZERO;
		end else begin
			unique case (CMD.sel)
				REG_COND: rd_word = regs[CMD.grp].cond;
				REG_RISE: rd_word = regs[CMD.grp].rise;
				REG_FALL: rd_word = regs[CMD.grp].fall;
				REG_EVT:  rd_word = regs[CMD.grp].evt;
				REG_MASK: rd_word = regs[CMD.grp].mask;
				default:  rd_word = WORD_ZERO;
			endcase
		end
	end

	// Query answers go into the queue
	assign push = accept && CMD.op == OP_READ && st_q.count != CNT_FULL;
	// Read strobe from the controller pops
	assign pop  = OQ_READ && st_q.count != CNT_EMPTY;

	always_comb begin
		st_d = st_q;
		// Two stage synchroniser for pin inputs
		st_d.sync1 = pins;
		st_d.sync2 = st_q.sync1;
		st_d.oq_valid = 1'b0;
		if (push) begin
			st_d.mem[st_q.wr_ptr] = rd_word;
			st_d.wr_ptr = OSQ_AW'(st_q.wr_ptr + 1'b1);
		end
		if (pop) begin
			st_d.oq_data  = st_q.mem[st_q.rd_ptr];
			st_d.oq_valid = 1'b1;
			st_d.rd_ptr   = OSQ_AW'(st_q.rd_ptr + 1'b1);
		end
		if (push && !pop) begin
			st_d.count = OSQ_CW'(st_q.count + 1'b1);
		end else if (pop && !push) begin
			st_d.count = OSQ_CW'(st_q.count - 1'b1);
		end
		st_d.message_available      = st_d.count != CNT_EMPTY;
		// Hold off commands while data pending
		st_d.ready    = st_d.count == CNT_EMPTY;
		st_d.stb_oper = sum[GRP_OPER];
		st_d.stb_ques = sum[GRP_QUES];
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Every output straight from a flip-flop
	assign CMD_READY             = st_q.ready;
	assign OQ_DATA               = st_q.oq_data;
	assign OQ_DATA_VALID         = st_q.oq_valid;
	assign STB_OPER_SUMMARY      = st_q.stb_oper;
	assign STB_QUES_SUMMARY      = st_q.stb_ques;
	assign STB_MESSAGE_AVAILABLE = st_q.message_available;

	// A query answer is taken back before the next command, so the queue
	// never holds more than one word; the depth of four is never filled.

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	sequence seq_prog_held;
		USER_PROGRAM_ACTIVE [*3];
	endsequence

	sequence seq_query_taken;
		CMD.valid && CMD_READY && CMD.op == OP_READ;
	endsequence

	chk_prog_bit: assert property (
		seq_prog_held |-> regs[GRP_OPER].cond[OPER_PROG])
		else $error("program activity not on operation bit 14");
	chk_oper_route: assert property (
		sum[GRP_OPER] |=> STB_OPER_SUMMARY)
		else $error("operation summary not on status bit seven");
	chk_ques_route: assert property (
		!sum[GRP_QUES] |=> !STB_QUES_SUMMARY)
		else $error("questionable summary bit stuck");
	chk_query_mav: assert property (
		seq_query_taken |=> STB_MESSAGE_AVAILABLE && !CMD_READY)
		else $error("query answer not flagged");
	chk_hold_cmds: assert property (
		STB_MESSAGE_AVAILABLE |-> !CMD_READY)
		else $error("command accepted with output pending");
	chk_read_data: assert property (
		(seq_query_taken ##1 (OQ_READ && !CMD.valid)) |=> OQ_DATA_VALID
		&& OQ_DATA == $past(rd_word, 2))
		else $error("queued answer lost");
	chk_mav_empty: assert property (
		(OQ_READ && st_q.count == 3'h1 && !push) |=> !STB_MESSAGE_AVAILABLE)
		else $error("message available after queue drained");
	chk_meas_bit0: assert property (
		regs[GRP_MEAS].cond[15:1] == 15'h0000)
		else $error("measuring group has extra bits");
	chk_meas_route: assert property (
		sum[GRP_MEAS] |-> regs[GRP_OPER].cond[OPER_MEAS])
		else $error("measuring summary not on operation bit 4");
	chk_cal_ques: assert property (
		st_q.sync2[PIN_CAL] |-> regs[GRP_QUES].cond[QUES_CAL])
		else $error("calibration summary missing");
endmodule : osq_status_top
`default_nettype wire

// ==== test/osq_ctrl_model.sv ====
// Remote bus controller model issuing status commands and draining replies
`timescale 1ns/1ps
`default_nettype none
module osq_ctrl_model
	import osq_pkg::*;
(
	input  wire logic        clk,
	output osq_pkg::osq_cmd_t cmd,
	input  wire logic        cmd_ready,
	output logic             oq_read,
	input  wire logic [15:0] oq_data,
	input  wire logic        oq_data_valid
);
	initial begin
		cmd = '0;
		oq_read = 1'b0;
	end

	task automatic send(input osq_op_t op, input osq_grp_t grp, input osq_reg_t sel,
			input logic [15:0] data, output bit ok);
		bit seen;
		ok = 1'b0;
		@(posedge clk);
		#1;
		cmd = '{valid: 1'b1, op: op, grp: grp, sel: sel, data: data};
		// Ready is registered: its value just after an edge is what the next edge uses
		for (int n = 0; n < 50 && !ok; n++) begin
			seen = (cmd_ready === 1'b1);
			@(posedge clk);
			#1;
			ok = seen;
		end
		// Released data flips so stale values never match by luck
		cmd = '{valid: 1'b0, op: op, grp: grp, sel: sel, data: ~data};
	endtask : send

	task automatic pop(output logic [15:0] word, output bit ok);
		ok = 1'b0;
		word = '0;
		oq_read = 1'b1;
		for (int n = 0; n < 50 && !ok; n++) begin
			@(posedge clk);
			#1;
			if (oq_data_valid === 1'b1) begin
				ok = 1'b1;
				word = oq_data;
			end
		end
		oq_read = 1'b0;
	endtask : pop
endmodule : osq_ctrl_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the status groups and output queue
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import osq_pkg::*;
	logic        sys_clk  = 1'b0;
	logic        rst_n    = 1'b0;
	logic [6:0]  pins     = 7'h00;
	osq_cmd_t    cmd;
	logic        cmd_ready;
	logic        oq_read;
	logic        oq_valid;
	logic        stb_oper;
	logic        stb_ques;
	logic        stb_mav;
	logic [15:0] oq_data;
	logic [15:0] word;
	bit          ok;
	int          errors   = 0;
	int          n_checks = 0;

	always #2.5 sys_clk = ~sys_clk;

	osq_status_top i_dut (.SYS_CLK(sys_clk), .RST_N(rst_n), .CMD(cmd), .CMD_READY(cmd_ready),
		.OQ_READ(oq_read), .OQ_DATA(oq_data), .OQ_DATA_VALID(oq_valid),
		.USER_PROGRAM_ACTIVE(pins[PIN_PROG]), .FRAME_ERROR_TEST_ACTIVE(pins[PIN_FER]),
		.CDMA2_SUMMARY(pins[PIN_CDMA2]), .CALL_PROC_SUMMARY(pins[PIN_CALLP]),
		.CDMA_SUMMARY(pins[PIN_CDMA]), .CAL_SUMMARY(pins[PIN_CAL]),
		.COMMAND_WARNING(pins[PIN_WARN]), .STB_OPER_SUMMARY(stb_oper),
		.STB_QUES_SUMMARY(stb_ques), .STB_MESSAGE_AVAILABLE(stb_mav));

	osq_ctrl_model i_ctrl (.clk(sys_clk), .cmd(cmd), .cmd_ready(cmd_ready), .oq_read(oq_read),
		.oq_data(oq_data), .oq_data_valid(oq_valid));

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	task automatic hung(string what);
		errors++;
		$display("ERROR %s expected handshake seen none", what);
		end_of_test();
	endtask : hung

	task automatic chk_word(string what, logic [15:0] exp, logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(string what, logic exp, logic got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	task automatic wr(osq_grp_t g, osq_reg_t s, logic [15:0] d);
		i_ctrl.send(OP_WRITE, g, s, d, ok);
		if (!ok) hung("write");
	endtask : wr

	task automatic rd(osq_grp_t g, osq_reg_t s, logic [15:0] exp, string what);
		i_ctrl.send(OP_READ, g, s, 16'h0000, ok);
		if (!ok) hung("query");
		i_ctrl.pop(word, ok);
		if (!ok) hung("queue read");
		chk_word(what, exp, word);
	endtask : rd

	task automatic wait_cyc(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wait_cyc

	initial begin
		repeat (6) @(posedge sys_clk);
		#1;
		rst_n = 1'b1;
		for (int g = 0; g < OSQ_GROUPS; g++) begin
			rd(osq_grp_t'(g), REG_RISE, RISE_RST, "rise reset");
			rd(osq_grp_t'(g), REG_FALL, FALL_RST, "fall reset");
			rd(osq_grp_t'(g), REG_EVT, EVT_RST, "event reset");
			rd(osq_grp_t'(g), REG_MASK, MASK_RST, "mask reset");
		end
		$display("test reset values done");
		wr(GRP_OPER, REG_RISE, 16'hFFFF);
		rd(GRP_OPER, REG_RISE, 16'h7FFF, "rise top bit");
		wr(GRP_QUES, REG_FALL, 16'h1234);
		rd(GRP_QUES, REG_FALL, 16'h1234, "fall write");
		wr(GRP_QUES, REG_MASK, 16'hABCD);
		rd(GRP_QUES, REG_MASK, 16'h2BCD, "mask top bit");
		wr(GRP_QUES, REG_MASK, 16'h0000);
		rd(GRP_QUES, REG_MASK, 16'h0000, "mask zero");
		wr(GRP_OPER, REG_COND, 16'h1111);
		rd(GRP_OPER, REG_COND, 16'h0000, "cond read only");
		$display("test register access done");
		pins = 7'h7F;
		wait_cyc(8);
		rd(GRP_OPER, REG_COND, 16'h4701, "oper cond");
		rd(GRP_QUES, REG_COND, 16'h4100, "ques cond");
		rd(GRP_MEAS, REG_COND, 16'h0001, "meas cond");
		rd(GRP_OPER, REG_EVT, 16'h4701, "oper rise events");
		rd(GRP_OPER, REG_EVT, 16'h0000, "event read clear");
		$display("test conditions done");
		wr(GRP_OPER, REG_FALL, 16'h4000);
		wr(GRP_OPER, REG_MASK, 16'h4000);
		chk_bit("oper summary idle", 1'b0, stb_oper);
		pins[PIN_PROG] = 1'b0;
		wait_cyc(8);
		chk_bit("oper summary fall", 1'b1, stb_oper);
		rd(GRP_OPER, REG_EVT, 16'h4000, "oper fall event");
		wait_cyc(4);
		chk_bit("oper summary after read", 1'b0, stb_oper);
		wr(GRP_QUES, REG_MASK, 16'h4000);
		wait_cyc(4);
		chk_bit("ques summary", 1'b1, stb_ques);
		rd(GRP_QUES, REG_EVT, 16'h4100, "ques events");
		wait_cyc(4);
		chk_bit("ques summary cleared", 1'b0, stb_ques);
		wr(GRP_OPER, REG_MASK, 16'h0010);
		wr(GRP_MEAS, REG_MASK, 16'h0001);
		wait_cyc(6);
		rd(GRP_OPER, REG_COND, 16'h0711, "meas into oper");
		chk_bit("oper via meas", 1'b1, stb_oper);
		i_ctrl.send(OP_CLEAR, GRP_OPER, REG_EVT, 16'h0000, ok);
		if (!ok) hung("clear status");
		wait_cyc(8);
		chk_bit("oper after clear", 1'b0, stb_oper);
		rd(GRP_MEAS, REG_EVT, 16'h0000, "meas event clear");
		pins = 7'h6A;
		wait_cyc(4);
		rd(GRP_OPER, REG_COND, 16'h0201, "subordinate bit order");
		$display("test events and summaries done");
		i_ctrl.send(OP_READ, GRP_OPER, REG_MASK, 16'h0000, ok);
		if (!ok) hung("query");
		chk_bit("message available", 1'b1, stb_mav);
		chk_bit("busy while pending", 1'b0, cmd_ready);
		wait_cyc(3);
		chk_bit("reply held", 1'b1, stb_mav);
		chk_bit("still busy", 1'b0, cmd_ready);
		i_ctrl.pop(word, ok);
		if (!ok) hung("queue read");
		chk_word("queued reply", 16'h0010, word);
		chk_bit("queue empty", 1'b0, stb_mav);
		$display("test output queue done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
